// >>> design/rla_core.sv
`timescale 1ns/1ps
// What this block does
// RULE1 - nibble 1001 writes A, 1010 writes B
// RULE2 - level code taken from bits 11 to 3
// RULE3 - host sends zero in bits 2 to 0
// RULE4 - level resets to 1FF; host avoids 064-000
// RULE5 - read nibbles 0011 cfg, 0001 A, 0010 B
// RULE6 - read frame needs 48 falling edges
// RULE7 - return frame needs 48 falling edges
// RULE8 - return word on out_a, then zeros
// RULE9 - serial_out_b driven low in return frame
// RULE10 - returned word: nibble then register bits
// RULE11 - write in return frame applies next frame
// RULE12 - first 16 bits latched, applied when validated
// RULE13 - short frame discards its command entirely
// RULE14 - other nibbles do nothing
// RULE15 - words move most significant bit first
// RULE16 - outputs high impedance outside frames
module rla_core
  import rla_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic bit_clock_i,
  input wire logic cs_n_i,
  input wire logic serial_in_i,
  input wire logic [11:0] config_word_i,
  output logic serial_out_a_o,
  output logic serial_out_a_oe_o,
  output logic serial_out_b_o,
  output logic serial_out_b_oe_o,
  output logic [8:0] ref_level_a_o,
  output logic [8:0] ref_level_b_o
);

  ////////////////////////////////////////////////////////////////////////////
  // link domain, clocked on bit_clock falling edges and, for the frame handoff, on cs rise
  logic [5:0] edge_cnt_q;
  logic [15:0] shift_in_q;
  logic [15:0] shift_out_q;
  logic out_a_q;
  logic rd_armed_q;
  logic frame_tgl_q;
  rla_word_t frame_word_q;
  logic [15:0] ret_word_q;
  logic first_edge;
  logic [5:0] need_edges;
  logic frame_ok;
  logic frame_is_read;

  // read nibbles 0001, 0010 and 0011, decoded on both sides of the crossing
  function automatic logic is_read_cmd(input logic [3:0] nib);
    return (nib[3:2] == 2'b00) && (nib[1:0] != 2'b00); // see RULE5
  endfunction

  // serial_out pins are not tri-stated here; their enables drop when cs is high
  assign first_edge = (edge_cnt_q == 6'd0);

  // bit_clock stands still between frames, so no handshake can come back on it;
  // the link arms its own return frame at cs rise instead

  // shift register, edge counter and return shifter
  always_ff @(negedge bit_clock_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      edge_cnt_q <= 6'd0;
      shift_in_q <= 16'h0000;
      out_a_q <= 1'b0;
      shift_out_q <= 16'h0000;
    end else begin
      if (edge_cnt_q != 6'h3F) begin
        edge_cnt_q <= edge_cnt_q + 6'd1;
      end
      if (edge_cnt_q < WORD_EDGES) begin
        shift_in_q <= {shift_in_q[14:0], serial_in_i}; // see RULE12 see RULE15
      end
      if (first_edge) begin
        // ret_word_q has settled for several core clocks since the last cs rise
        shift_out_q <= rd_armed_q ? {ret_word_q[14:0], 1'b0} : 16'h0000; // see RULE15
        out_a_q <= rd_armed_q && ret_word_q[15]; // see RULE8 see RULE10
      end else begin
        out_a_q <= shift_out_q[15]; // see RULE8
        shift_out_q <= {shift_out_q[14:0], 1'b0};
      end
    end
  end
  // reads need 48 edges, writes need the shorter count
  assign need_edges = (shift_in_q[15:14] == 2'b00) ? READ_EDGES : WRITE_EDGES; // see RULE6
  assign frame_ok = (edge_cnt_q >= need_edges);
  assign frame_is_read = is_read_cmd(shift_in_q[15:12]);

  // hand a validated frame to the core when cs rises; reset reaches this
  // domain asynchronously because its own clock only runs inside frames
  always_ff @(posedge cs_n_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame_word_q <= rla_word_t'(16'h0000);
      frame_tgl_q <= 1'b0;
      rd_armed_q <= 1'b0;
    end else begin
      if (frame_ok) begin
        frame_word_q <= rla_word_t'(shift_in_q); // see RULE13
        frame_tgl_q <= ~frame_tgl_q;
      end
      rd_armed_q <= frame_ok && frame_is_read; // see RULE13
    end
  end

  assign serial_out_a_o = out_a_q;
  assign serial_out_a_oe_o = ~cs_n_i; // see RULE16
  assign serial_out_b_o = 1'b0; // see RULE9
  assign serial_out_b_oe_o = ~cs_n_i;

  ////////////////////////////////////////////////////////////////////////////
  // core domain
  logic tgl_s1_q;
  logic tgl_s2_q;
  logic tgl_s3_q;
  logic [8:0] lvl_a_q;
  logic [8:0] lvl_b_q;
  logic new_frame;
  logic [3:0] cmd;
  logic [15:0] ret_next;

  assign new_frame = tgl_s2_q ^ tgl_s3_q;
  assign cmd = frame_word_q.cmd;

  // answer word for a read command
  always_comb begin
    case (cmd)
      CMD_RD_CFG: ret_next = {cmd, config_word_i}; // see RULE10
      CMD_RD_A: ret_next = {cmd, lvl_a_q, 3'b000};
      CMD_RD_B: ret_next = {cmd, lvl_b_q, 3'b000};
      default: ret_next = 16'h0000;
    endcase
  end

  // synchronise the frame toggle and decode
  always_ff @(posedge clk_i) begin
    tgl_s1_q <= frame_tgl_q;
    tgl_s2_q <= tgl_s1_q;
    tgl_s3_q <= tgl_s2_q;
    if (!reset_n_i) begin
      lvl_a_q <= LVL_RESET; // see RULE4
      lvl_b_q <= LVL_RESET;
      ret_word_q <= 16'h0000;
    end else if (new_frame) begin
      if (cmd == CMD_WR_A) lvl_a_q <= frame_word_q.body[LVL_MSB:LVL_LSB]; // see RULE1 see RULE2
      if (cmd == CMD_WR_B) lvl_b_q <= frame_word_q.body[LVL_MSB:LVL_LSB]; // see RULE11
      ret_word_q <= ret_next; // see RULE14
    end
  end

  assign ref_level_a_o = lvl_a_q;
  assign ref_level_b_o = lvl_b_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_lvl_write;
    @(posedge clk_i) disable iff (!reset_n_i)
      (new_frame && cmd == CMD_WR_A) |=> (lvl_a_q == $past(frame_word_q.body[11:3]));
  endproperty
  a_lvl_write: assert property (p_lvl_write) else $error("level a not written"); // see RULE2

  property p_lvl_write_b;
    @(posedge clk_i) disable iff (!reset_n_i)
      (new_frame && cmd == CMD_WR_B) |=> (lvl_b_q == $past(frame_word_q.body[LVL_MSB:LVL_LSB]));
  endproperty
  a_lvl_write_b: assert property (p_lvl_write_b) else $error("level b not written"); // see RULE1

  property p_lvl_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
      (!new_frame) |=> $stable(lvl_b_q);
  endproperty
  a_lvl_hold: assert property (p_lvl_hold) else $error("level b changed"); // see RULE14

  property p_lvl_hold_a;
    @(posedge clk_i) disable iff (!reset_n_i)
      (!new_frame) |=> $stable(lvl_a_q);
  endproperty
  a_lvl_hold_a: assert property (p_lvl_hold_a) else $error("level a changed"); // see RULE13

  property p_ret_word;
    @(posedge clk_i) disable iff (!reset_n_i)
      (new_frame && cmd == CMD_RD_B) |=> (ret_word_q[15:12] == CMD_RD_B && ret_word_q[2:0] == 3'b000);
  endproperty
  a_ret_word: assert property (p_ret_word) else $error("bad return word"); // see RULE10

  property p_b_low;
    @(negedge bit_clock_i) !cs_n_i |-> (serial_out_b_o == 1'b0);
  endproperty
  a_b_low: assert property (p_b_low) else $error("out b not low"); // see RULE9

  property p_tail_zero;
    @(negedge bit_clock_i) disable iff (cs_n_i)
      (edge_cnt_q > 6'd16) |-> (out_a_q == 1'b0);
  endproperty
  a_tail_zero: assert property (p_tail_zero) else $error("out a not zero"); // see RULE8

  property p_idle_frame;
    @(negedge bit_clock_i) disable iff (cs_n_i)
      (first_edge && !rd_armed_q) |=> (out_a_q == 1'b0);
  endproperty
  a_idle_frame: assert property (p_idle_frame) else $error("out a set without read"); // see RULE8

  property p_ret_first;
    @(negedge bit_clock_i) disable iff (cs_n_i)
      (first_edge && rd_armed_q) |=> (out_a_q == $past(ret_word_q[15]));
  endproperty
  a_ret_first: assert property (p_ret_first) else $error("bad first return bit"); // see RULE10

  property p_oe;
    @(posedge clk_i) disable iff (!reset_n_i)
      cs_n_i |-> (!serial_out_a_oe_o && !serial_out_b_oe_o);
  endproperty
  a_oe: assert property (p_oe) else $error("driving outside frame"); // see RULE16

  property p_reset_lvl;
    @(posedge clk_i) !reset_n_i |=> (lvl_a_q == 9'h1FF && lvl_b_q == 9'h1FF);
  endproperty
  a_reset_lvl: assert property (p_reset_lvl) else $error("bad level reset"); // see RULE4

  property p_cfg_ret;
    @(posedge clk_i) disable iff (!reset_n_i)
      (new_frame && cmd == CMD_RD_CFG) |=> (ret_word_q[11:0] == $past(config_word_i));
  endproperty
  a_cfg_ret: assert property (p_cfg_ret) else $error("bad config return"); // see RULE10

endmodule

// >>> design/rla_pkg.sv
package rla_pkg;
  // command nibbles
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_RD_A = 4'h1;
  localparam logic [3:0] CMD_RD_B = 4'h2;
  localparam logic [3:0] CMD_RD_CFG = 4'h3;
  localparam logic [3:0] CMD_WR_CFG = 4'h8;
  localparam logic [3:0] CMD_WR_A = 4'h9;
  localparam logic [3:0] CMD_WR_B = 4'hA;
  // field positions in the command word
  localparam int CMD_MSB = 15;
  localparam int CMD_LSB = 12;
  localparam int LVL_MSB = 11;
  localparam int LVL_LSB = 3;
  // reset values and frame counts
  localparam logic [8:0] LVL_RESET = 9'h1FF;
  localparam logic [11:0] CFG_RESET = 12'h000;
  localparam logic [5:0] WORD_EDGES = 6'd16;
  localparam logic [5:0] READ_EDGES = 6'd48;
  localparam logic [5:0] WRITE_EDGES = 6'd32;

  // one validated frame handed to the core domain
  typedef struct packed {
    logic [3:0] cmd;
    logic [11:0] body;
  } rla_word_t;
endpackage

// >>> testbench/rla_host.sv
`timescale 1ns/1ps
// host model: link clock idles high, frames framed by cs
module rla_host (
  output logic bit_clock_o,
  output logic cs_n_o,
  output logic serial_in_o,
  input wire logic serial_out_a_i,
  input wire logic serial_out_b_i
);
  initial begin
    bit_clock_o = 1'b1;
    cs_n_o = 1'b1;
    serial_in_o = 1'b0;
  end
  // n falls, word out msb first, first 16 returned bits in r
  task automatic frame(input logic [15:0] w, input int n, output logic [15:0] r,
                       output logic z);
    z = 1'b0;
    r = 16'h0000;
    cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      serial_in_o = (i < 16) ? w[15 - i] : 1'b0;
      #6 bit_clock_o = 1'b0;
      #6 bit_clock_o = 1'b1;
      if (i < 16) r[15 - i] = serial_out_a_i;
      else z = z | serial_out_a_i;
      z = z | serial_out_b_i;
    end
    #6 cs_n_o = 1'b1;
    serial_in_o = ~serial_in_o;
    #200;
  endtask
endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import rla_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b1;
  logic [11:0] cfg = 12'h000;
  wire bclk, cs_n, serial_in, sda, sdb, oe_a, oe_b;
  wire [8:0] lvl_a, lvl_b;
  logic [8:0] ea, eb, v;
  logic [15:0] r;
  logic z;
  logic [3:0] nop[5] = '{4'h0, 4'hB, 4'h4, 4'hC, CMD_WR_CFG};
  int num_errors = 0;
  int checks = 0;
  int seed = 36;
  always #12.5 clk_i = ~clk_i;
  rla_host host (.bit_clock_o(bclk), .cs_n_o(cs_n), .serial_in_o(serial_in),
    .serial_out_a_i(sda), .serial_out_b_i(sdb));
  rla_core dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .bit_clock_i(bclk),
    .cs_n_i(cs_n), .serial_in_i(serial_in), .config_word_i(cfg), .serial_out_a_o(sda),
    .serial_out_a_oe_o(oe_a), .serial_out_b_o(sdb), .serial_out_b_oe_o(oe_b),
    .ref_level_a_o(lvl_a), .ref_level_b_o(lvl_b));
  // expected level readback word
  function automatic logic [15:0] rd_word(input logic [3:0] c, input logic [8:0] l);
    return {c, l, 3'b000};
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // read command frame, then return frame carrying w
  task automatic read_back(input logic [3:0] c, input logic [15:0] w, input logic [15:0] e);
    host.frame({c, 12'h000}, 48, r, z);
    host.frame(w, 48, r, z);
    cmp(r, e);
    cmp({15'h0000, z}, 16'h0000);
  endtask
  task automatic levels;
    cmp({7'h00, lvl_a}, {7'h00, ea});
    cmp({7'h00, lvl_b}, {7'h00, eb});
  endtask
  // hang guard
  initial begin
    repeat (60000) @(posedge clk_i);
    num_errors++;
    end_sim;
  end
  // main sequence
  initial begin
    #1 reset_n_i = 1'b0;
    repeat (10) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    ea = LVL_RESET;
    eb = LVL_RESET;
    #100 levels;
    cmp({15'h0000, oe_a}, 16'h0000);
    cmp({15'h0000, oe_b}, 16'h0000);
    for (int k = 0; k < 6; k++) begin
      v = 9'h065 + 9'(($random(seed) & 32'h7FFF_FFFF) % 32'h0000_019B);
      cfg = 12'($random(seed));
      ea = v;
      eb = 9'h264 - v;
      host.frame({CMD_WR_A, ea, 3'b000}, 32, r, z);
      host.frame({CMD_WR_B, eb, 3'b000}, 32, r, z);
      levels;
      read_back(CMD_RD_A, 16'h0000, rd_word(CMD_RD_A, ea));
      read_back(CMD_RD_B, 16'h0000, rd_word(CMD_RD_B, eb));
      read_back(CMD_RD_CFG, 16'h0000, {CMD_RD_CFG, cfg});
    end
    host.frame({CMD_WR_A, 9'h080, 3'b000}, 31, r, z);
    levels;
    foreach (nop[i]) host.frame({nop[i], 12'h5A8}, 48, r, z);
    levels;
    read_back(CMD_RD_A, {CMD_WR_A, 9'h065, 3'b000}, rd_word(CMD_RD_A, ea));
    ea = 9'h065;
    levels;
    cmp({15'h0000, oe_a}, 16'h0000);
    cmp({15'h0000, oe_b}, 16'h0000);
    end_sim;
  end
endmodule
